// ---- hdl/modem_status_defs.vh ----
`ifndef MODEM_STATUS_DEFS_VH
`define MODEM_STATUS_DEFS_VH

// register offsets
`define ADDR_RX_BUFFER    8'h00
`define ADDR_RELAY_B      8'h04
`define ADDR_PARITY_CTL   8'h06
`define ADDR_RELAY_A      8'h07
`define ADDR_CALL_MODE    8'h09
`define ADDR_RX_ERROR     8'h0A
`define ADDR_TRAIN_DET    8'h0D
`define ADDR_PARITY_SEL   8'h11
`define ADDR_TONE_DET     8'h1B
`define ADDR_IRQ_CFG      8'h1F
`define ADDR_MODE_EXTRA   8'h20
`define ADDR_RX_EXTRA     8'h21

// field positions
`define BIT_RELAY_TWO     7
`define BIT_PARITY_EN     3
`define BIT_RELAY_ONE     1
`define BIT_TONE_SUPP     7
`define BIT_ORIGINATE     4
`define BIT_TRAIN_OK      7
`define BIT_PARITY_ERR    5
`define BIT_OVERRUN       3
`define BIT_SEG_TWO       7
`define BIT_SEG_NOISE     6
`define PSEL_HI           6
`define PSEL_LO           5
`define BIT_ON_TIME       5
`define BIT_IRQ_ACTIVE    7
`define BIT_IRQ_ENABLE    4
`define BIT_STATUS_NEW    3
`define BIT_CFG_REQ       0
`define BIT_TX_NINTH      0
`define BIT_RX_NINTH      1
`define BIT_ASYNC_MODE    2
`define BIT_FRAMING_ERR   0

// parity methods
`define PAR_STUFF         2'h0
`define PAR_SPACE         2'h1
`define PAR_EVEN          2'h2
`define PAR_ODD           2'h3

// reset values
`define RST_BYTE          8'h00
`define RST_PSEL          2'h0

`endif

// ---- hdl/parity_calc.v ----
`timescale 1ns/10ps
`default_nettype none
`include "modem_status_defs.vh"

module parity_calc (
  input  wire [1:0] method,     // parity method code
  input  wire [7:0] data,       // character
  input  wire       ninth_in,   // stuffed ninth data bit
  output reg        parity_bit  // parity bit for this character
);

  always @* begin
    case (method)
      `PAR_STUFF: parity_bit = ninth_in;
      `PAR_SPACE: parity_bit = 1'b0;
      `PAR_EVEN:  parity_bit = ^data;
      default:    parity_bit = ~^data;
    endcase
  end

endmodule

`default_nettype wire

// ---- hdl/config_apply.v ----
`timescale 1ns/10ps
`default_nettype none
`include "modem_status_defs.vh"

module config_apply (
  input  wire clk,              // clock
  input  wire rst,              // async reset, high
  input  wire apply_req,        // pending configuration request
  input  wire originate_sel,    // originate bit as written
  input  wire tone_suppress,    // answer tone suppress bit
  input  wire auto_mode,        // automatic mode selection active
  input  wire handshake_start,  // handshake begins, pulse
  input  wire handshake_end,    // handshake over, pulse
  output reg  originate_q,      // originate mode in effect
  output reg  apply_done_q,     // configuration taken, pulse
  output reg  answer_tone_q     // answer tone being sent
);

  // new mode only takes effect through the request, which is applied even mid-call
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      originate_q  <= 1'b0;
      apply_done_q <= 1'b0;
    end else begin
      apply_done_q <= apply_req & ~apply_done_q;
      if (apply_req & ~apply_done_q) begin
        originate_q <= originate_sel;
      end
    end
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      answer_tone_q <= 1'b0;
    end else if (handshake_start) begin
      // suppression ignored under automatic mode
      answer_tone_q <= ~originate_q & (~tone_suppress | auto_mode);
    end else if (handshake_end) begin
      answer_tone_q <= 1'b0;
    end
  end

endmodule

`default_nettype wire

// ---- hdl/modem_host_status_control_bits.v ----
// What this block does
// - enabled new status raises interrupt and active flag
// - suppress bit omits answer tone in answer mode
// - suppression ignored in automatic mode
// - overrun set when unread byte overwritten
// - overrun in async and HDLC, host clears
// - originate bit one originate, zero answer
// - DTMF receiver sets on-time flag when met
// - on-time flag cleared on digit or off-time fail
// - second segment flag follows its detection
// - parity method field picks stuff/space/even/odd
// - parity error on bad parity or CRC
// - voice first low byte sets framing and parity
// - parity enable generates and checks async parity
// - noise segment flag follows its detection
// - training success set at noise segment end
// - off-hook relay output low while bit one
// - relay_n_a relay output low while bit one
// - writing zero to new status clears active flag
// - device clears config request once applied
`timescale 1ns/10ps
`default_nettype none
`include "modem_status_defs.vh"

module modem_host_status_control_bits (
  input  wire       clk,                   // 25 MHz clock
  input  wire       rst,                   // async reset, high
  input  wire [7:0] reg_addr,              // register address
  input  wire [7:0] reg_wdata,             // write data
  input  wire       reg_wr,                // write strobe
  input  wire       reg_rd,                // read strobe
  output reg  [7:0] reg_rdata,             // read data, cycle after
  input  wire       status_event,          // engine posts new status
  input  wire       rx_load,               // engine loads a byte
  input  wire [7:0] rx_data,               // received byte
  input  wire       rx_ninth_in,           // received parity/ninth bit
  input  wire       rx_framing_err,        // byte had framing error
  input  wire       hdlc_mode,             // synchronous HDLC active
  input  wire       voice_mode,            // voice receive active
  input  wire       crc_bad,               // bad CRC seen, pulse
  input  wire       voice_first_low,       // first low voice byte
  input  wire       dtmf_receiver,         // configured as DTMF rx
  input  wire       tone_on_time_met,      // on-time met, pulse
  input  wire       tone_digit_detected,   // digit detected, pulse
  input  wire       tone_off_time_fail,    // off-time failed, pulse
  input  wire       second_segment_detect, // second segment seen
  input  wire       noise_segment_detect,  // noise segment seen
  input  wire       training_start,        // new training begins
  input  wire       training_success,      // trained at segment end
  input  wire       handshake_start,       // handshake begins
  input  wire       handshake_end,         // handshake over
  input  wire       auto_mode,             // automatic mode selection
  input  wire [7:0] tx_char,               // character to send
  output reg        tx_parity_bit,         // parity bit for tx_char
  output reg        tx_parity_on,          // parity appended
  output wire       irq,                   // interrupt request, high
  output wire       originate_active,      // originate mode in effect
  output wire       answer_tone_send,      // send answer tone
  output wire       config_applied,        // config taken, pulse
  output reg        async_active,          // async mode in effect
  output wire       off_hook_relay_n,      // off-hook relay, low on
  output wire       relay_n_a              // relay_n_a relay, low on
);

  ////////////////////////////////////////////////////////////////////
  // host access decode

  wire wr_rx_error = reg_wr & (reg_addr == `ADDR_RX_ERROR);
  wire wr_irq_cfg  = reg_wr & (reg_addr == `ADDR_IRQ_CFG);
  wire rd_rx_buf   = reg_rd & (reg_addr == `ADDR_RX_BUFFER);

  ////////////////////////////////////////////////////////////////////
  // control registers

  reg       relay_two_activate_q;
  reg       relay_one_activate_q;
  reg       parity_enable_bit_q;
  reg       answer_tone_suppress_q;
  reg       originate_select_q;
  reg [1:0] parity_method_select_q;
  reg       status_irq_enable_q;
  reg       transmit_ninth_bit_q;
  reg       async_mode_select_q;

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      relay_two_activate_q   <= 1'b0;
      relay_one_activate_q   <= 1'b0;
      parity_enable_bit_q    <= 1'b0;
      answer_tone_suppress_q <= 1'b0;
      originate_select_q     <= 1'b0;
      parity_method_select_q <= `RST_PSEL;
      status_irq_enable_q    <= 1'b0;
      transmit_ninth_bit_q   <= 1'b0;
      async_mode_select_q    <= 1'b0;
    end else if (reg_wr) begin
      if (reg_addr == `ADDR_RELAY_B) begin
        relay_two_activate_q <= reg_wdata[`BIT_RELAY_TWO];
      end else if (reg_addr == `ADDR_PARITY_CTL) begin
        parity_enable_bit_q <= reg_wdata[`BIT_PARITY_EN];
      end else if (reg_addr == `ADDR_RELAY_A) begin
        relay_one_activate_q <= reg_wdata[`BIT_RELAY_ONE];
      end else if (reg_addr == `ADDR_CALL_MODE) begin
        answer_tone_suppress_q <= reg_wdata[`BIT_TONE_SUPP];
        originate_select_q     <= reg_wdata[`BIT_ORIGINATE];
      end else if (reg_addr == `ADDR_PARITY_SEL) begin
        parity_method_select_q <= reg_wdata[`PSEL_HI:`PSEL_LO];
      end else if (reg_addr == `ADDR_IRQ_CFG) begin
        status_irq_enable_q <= reg_wdata[`BIT_IRQ_ENABLE];
      end else if (reg_addr == `ADDR_MODE_EXTRA) begin
        transmit_ninth_bit_q <= reg_wdata[`BIT_TX_NINTH];
        // parity enable must already be right here
        async_mode_select_q  <= reg_wdata[`BIT_ASYNC_MODE];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // relay drivers, registered and active low

  reg off_hook_n_q;
  reg relay_n_a_n_q;

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      off_hook_n_q <= 1'b1;
      relay_n_a_n_q     <= 1'b1;
    end else begin
      off_hook_n_q <= ~relay_one_activate_q;
      relay_n_a_n_q     <= ~relay_two_activate_q;
    end
  end

  assign off_hook_relay_n = off_hook_n_q;
  assign relay_n_a        = relay_n_a_n_q;

  ////////////////////////////////////////////////////////////////////
  // configuration request and mode apply

  reg  config_apply_request_q;
  wire apply_done;

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      config_apply_request_q <= 1'b0;
    end else if (wr_irq_cfg & reg_wdata[`BIT_CFG_REQ]) begin
      // host set wins over a completion in the same cycle
      config_apply_request_q <= 1'b1;
    end else if (apply_done) begin
      config_apply_request_q <= 1'b0;
    end
  end

  config_apply u_apply (
    .clk             (clk),
    .rst             (rst),
    .apply_req       (config_apply_request_q),
    .originate_sel   (originate_select_q),
    .tone_suppress   (answer_tone_suppress_q),
    .auto_mode       (auto_mode),
    .handshake_start (handshake_start),
    .handshake_end   (handshake_end),
    .originate_q     (originate_active),
    .apply_done_q    (apply_done),
    .answer_tone_q   (answer_tone_send)
  );

  assign config_applied = apply_done;

  ////////////////////////////////////////////////////////////////////
  // new status and interrupt

  reg  status_changed_q;
  reg  status_irq_active_q;
  wire host_clr_status = wr_irq_cfg & ~reg_wdata[`BIT_STATUS_NEW];

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      status_changed_q    <= 1'b0;
      status_irq_active_q <= 1'b0;
    end else begin
      // host can only clear; a write of one is not accepted
      if (status_event) begin
        status_changed_q <= 1'b1;
      end else if (host_clr_status) begin
        status_changed_q <= 1'b0;
      end
      if (status_event & status_irq_enable_q) begin
        status_irq_active_q <= 1'b1;
      end else if (host_clr_status) begin
        status_irq_active_q <= 1'b0;
      end
    end
  end

  assign irq = status_irq_active_q;

  ////////////////////////////////////////////////////////////////////
  // parity generate and check

  wire rx_expect;
  wire tx_gen;
  wire par_live = async_mode_select_q & parity_enable_bit_q;

  parity_calc u_rx_par (
    .method     (parity_method_select_q),
    .data       (rx_data),
    .ninth_in   (rx_ninth_in),
    .parity_bit (rx_expect)
  );

  parity_calc u_tx_par (
    .method     (parity_method_select_q),
    .data       (tx_char),
    .ninth_in   (transmit_ninth_bit_q),
    .parity_bit (tx_gen)
  );

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      tx_parity_bit <= 1'b0;
      tx_parity_on  <= 1'b0;
      async_active  <= 1'b0;
    end else begin
      tx_parity_bit <= tx_gen;
      tx_parity_on  <= par_live;
      async_active  <= async_mode_select_q;
    end
  end

  // stuff method echoes the ninth bit, so it never mismatches
  wire rx_bad_par = par_live & (rx_ninth_in != rx_expect);

  ////////////////////////////////////////////////////////////////////
  // receive buffer, overrun, parity and framing status

  reg [7:0] receive_byte_buffer_q;
  reg       receive_ninth_bit_q;
  reg       rx_full_q;
  reg       overrun_q;
  reg       parity_crc_error_q;
  reg       framing_error_flag_q;

  wire framed_mode = async_mode_select_q | hdlc_mode;
  // a read in the same cycle as the load counts as in time
  wire overrun_hit = rx_load & rx_full_q & ~rd_rx_buf & framed_mode;

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      receive_byte_buffer_q <= `RST_BYTE;
      receive_ninth_bit_q   <= 1'b0;
      rx_full_q             <= 1'b0;
      overrun_q             <= 1'b0;
    end else begin
      if (rx_load) begin
        receive_byte_buffer_q <= rx_data;
        receive_ninth_bit_q   <= rx_ninth_in;
        rx_full_q             <= 1'b1;
      end else if (rd_rx_buf) begin
        rx_full_q <= 1'b0;
      end
      if (overrun_hit) begin
        overrun_q <= 1'b1;
      end else if (wr_rx_error & ~reg_wdata[`BIT_OVERRUN]) begin
        overrun_q <= 1'b0;
      end
    end
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      parity_crc_error_q   <= 1'b0;
      framing_error_flag_q <= 1'b0;
    end else if (voice_mode & voice_first_low) begin
      parity_crc_error_q   <= 1'b1;
      framing_error_flag_q <= 1'b1;
    end else if (hdlc_mode & crc_bad) begin
      parity_crc_error_q <= 1'b1;
    end else if (rx_load & async_mode_select_q) begin
      parity_crc_error_q   <= rx_bad_par;
      framing_error_flag_q <= rx_framing_err;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // training and tone status

  reg second_segment_detect_q;
  reg noise_segment_detect_q;
  reg training_success_q;
  reg tone_on_time_met_q;

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      second_segment_detect_q <= 1'b0;
      noise_segment_detect_q  <= 1'b0;
      training_success_q      <= 1'b0;
      tone_on_time_met_q      <= 1'b0;
    end else begin
      second_segment_detect_q <= second_segment_detect;
      noise_segment_detect_q  <= noise_segment_detect;
      if (training_success) begin
        training_success_q <= 1'b1;
      end else if (training_start) begin
        training_success_q <= 1'b0;
      end
      if (dtmf_receiver & tone_on_time_met) begin
        tone_on_time_met_q <= 1'b1;
      end else if (tone_digit_detected | tone_off_time_fail) begin
        tone_on_time_met_q <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // read mux; unmapped addresses and spare bits read zero

  reg [7:0] rd_mux;

  always @* begin
    rd_mux = 8'h00;
    if (reg_addr == `ADDR_RX_BUFFER) begin
      rd_mux = receive_byte_buffer_q;
    end else if (reg_addr == `ADDR_RELAY_B) begin
      rd_mux[`BIT_RELAY_TWO] = relay_two_activate_q;
    end else if (reg_addr == `ADDR_PARITY_CTL) begin
      rd_mux[`BIT_PARITY_EN] = parity_enable_bit_q;
    end else if (reg_addr == `ADDR_RELAY_A) begin
      rd_mux[`BIT_RELAY_ONE] = relay_one_activate_q;
    end else if (reg_addr == `ADDR_CALL_MODE) begin
      rd_mux[`BIT_TONE_SUPP] = answer_tone_suppress_q;
      rd_mux[`BIT_ORIGINATE] = originate_select_q;
    end else if (reg_addr == `ADDR_RX_ERROR) begin
      rd_mux[`BIT_TRAIN_OK]   = training_success_q;
      rd_mux[`BIT_PARITY_ERR] = parity_crc_error_q;
      rd_mux[`BIT_OVERRUN]    = overrun_q;
    end else if (reg_addr == `ADDR_TRAIN_DET) begin
      rd_mux[`BIT_SEG_TWO]   = second_segment_detect_q;
      rd_mux[`BIT_SEG_NOISE] = noise_segment_detect_q;
    end else if (reg_addr == `ADDR_PARITY_SEL) begin
      rd_mux[`PSEL_HI:`PSEL_LO] = parity_method_select_q;
    end else if (reg_addr == `ADDR_TONE_DET) begin
      rd_mux[`BIT_ON_TIME] = tone_on_time_met_q;
    end else if (reg_addr == `ADDR_IRQ_CFG) begin
      rd_mux[`BIT_IRQ_ACTIVE] = status_irq_active_q;
      rd_mux[`BIT_IRQ_ENABLE] = status_irq_enable_q;
      rd_mux[`BIT_STATUS_NEW] = status_changed_q;
      rd_mux[`BIT_CFG_REQ]    = config_apply_request_q;
    end else if (reg_addr == `ADDR_MODE_EXTRA) begin
      rd_mux[`BIT_TX_NINTH]   = transmit_ninth_bit_q;
      rd_mux[`BIT_RX_NINTH]   = receive_ninth_bit_q;
      rd_mux[`BIT_ASYNC_MODE] = async_mode_select_q;
    end else if (reg_addr == `ADDR_RX_EXTRA) begin
      rd_mux[`BIT_FRAMING_ERR] = framing_error_flag_q;
    end
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      reg_rdata <= rd_mux;
    end else begin
      reg_rdata <= 8'h00;
    end
  end

endmodule

`default_nettype wire

// ---- verif/status_bits_props.sv ----
`timescale 1ns/10ps
`default_nettype none
module status_bits_props (
  input wire logic       clk,              // clock
  input wire logic       rst,              // async reset, high
  input wire logic [7:0] reg_addr,         // register address
  input wire logic [7:0] reg_wdata,        // write data
  input wire logic       reg_wr,           // write strobe
  input wire logic       status_event,     // new status pulse
  input wire logic       handshake_start,  // handshake begins
  input wire logic       handshake_end,    // handshake over
  input wire logic       auto_mode,        // automatic mode selection
  input wire logic       irq,              // interrupt request
  input wire logic       originate_active, // originate in effect
  input wire logic       answer_tone_send, // answer tone on
  input wire logic       config_applied,   // config taken pulse
  input wire logic       off_hook_relay_n, // off-hook relay, low on
  input wire logic       relay_n_a         // relay_n_a relay, low on
);
  // control bits as written on the bus
  logic en_q, r1_q, r2_q, orig_q, supp_q;
  wire  wr_irq = reg_wr && reg_addr == 8'h1F;

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      {en_q, r1_q, r2_q, orig_q, supp_q} <= 5'h00;
    end else if (reg_wr) begin
      case (reg_addr)
        8'h1F: en_q <= reg_wdata[4];
        8'h07: r1_q <= reg_wdata[1];
        8'h04: r2_q <= reg_wdata[7];
        8'h09: {supp_q, orig_q} <= {reg_wdata[7], reg_wdata[4]};
        default: ;
      endcase
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  ////////////////////////////////////////////////////////////////////////
  a_irq_cause: assert property (
    $rose(irq) |-> $past(status_event) && $past(en_q))
    else $error("irq rose unprompted");
  a_irq_set: assert property (
    status_event && en_q |=> irq)
    else $error("irq not raised");
  a_irq_clear: assert property (
    wr_irq && !reg_wdata[3] && !status_event |=> !irq)
    else $error("irq not cleared");
  a_relay_one: assert property (
    r1_q == $past(r1_q) |-> off_hook_relay_n == !r1_q)
    else $error("relay one wrong");
  a_relay_two: assert property (
    r2_q == $past(r2_q) |-> relay_n_a == !r2_q)
    else $error("relay two wrong");
  a_cfg_apply: assert property (
    wr_irq && reg_wdata[0] |-> ##[1:2] config_applied)
    else $error("config not applied");
  a_orig_apply: assert property (
    config_applied |-> originate_active == orig_q)
    else $error("applied mode wrong");
  a_orig_hold: assert property (
    $changed(originate_active) |-> config_applied)
    else $error("mode changed unasked");
  a_tone_pick: assert property (
    handshake_start && !handshake_end |=> answer_tone_send ==
      (!$past(originate_active) && (!$past(supp_q) || $past(auto_mode))))
    else $error("answer tone wrong");
endmodule

bind modem_host_status_control_bits status_bits_props u_props (
  .clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .status_event(status_event),
  .handshake_start(handshake_start), .handshake_end(handshake_end),
  .auto_mode(auto_mode), .irq(irq), .originate_active(originate_active),
  .answer_tone_send(answer_tone_send), .config_applied(config_applied),
  .off_hook_relay_n(off_hook_relay_n), .relay_n_a(relay_n_a));
`default_nettype wire

// ---- verif/host_cpu_model.sv ----
`timescale 1ns/10ps
`default_nettype none
module host_cpu_model (
  input  wire logic       clk,       // clock
  output var  logic [7:0] reg_addr,  // register address
  output var  logic [7:0] reg_wdata, // write data
  output var  logic       reg_wr,    // write strobe
  output var  logic       reg_rd,    // read strobe
  input  wire logic [7:0] reg_rdata  // read data
);
  initial begin
    reg_addr  = 8'h00;
    reg_wdata = 8'h00;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
  end

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr    <= 1'b0;
    reg_wdata <= ~d; // inverted data, strobe low
    #1;
  endtask

  // data stand the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd   <= 1'b0;
    #1 d = reg_rdata;
  endtask

  task automatic apply_config(input logic [7:0] mode);
    wr(8'h09, mode);
    wr(8'h1F, 8'h01);
  endtask

  task automatic async_on(input logic parity_enable_bit);
    wr(8'h06, {4'h0, parity_enable_bit, 3'h0});
    wr(8'h20, 8'h04);
  endtask

  task automatic clear_overrun();
    wr(8'h0A, 8'h00);
  endtask
endmodule
`default_nettype wire

// ---- verif/modem_host_status_control_bits_test.sv ----
`timescale 1ns/10ps
`default_nettype none
module modem_host_status_control_bits_test;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [10:0] pl = 11'h000; // engine pulses
  logic [5:0]  lv = 6'h00;   // engine levels
  logic [7:0]  rx_data = 8'h00;
  logic        rx_ninth_in = 1'b0;
  logic        rx_framing_err = 1'b0;
  logic [7:0]  tx_char = 8'h07;
  wire  [7:0]  reg_addr, reg_wdata, reg_rdata;
  wire         reg_wr, reg_rd, tx_parity_bit, tx_parity_on, irq, async_active;
  wire         originate_active, answer_tone_send, relay_a_n, relay_b_n;
  logic [7:0]  d;
  logic [7:0]  addrs [0:8] = '{8'h04, 8'h06, 8'h07, 8'h09, 8'h0A, 8'h0D,
                               8'h11, 8'h1B, 8'h1F};
  int          error_cnt = 0;
  int          compares = 0;
  int          cycles = 0;

  always #20 clk = ~clk;

  host_cpu_model host (.clk(clk), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata));

  modem_host_status_control_bits dut (.clk(clk), .rst(rst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .status_event(pl[0]),
    .rx_load(pl[1]), .rx_data(rx_data), .rx_ninth_in(rx_ninth_in),
    .rx_framing_err(rx_framing_err), .hdlc_mode(lv[0]),
    .voice_mode(lv[1]), .crc_bad(pl[2]), .voice_first_low(pl[3]),
    .dtmf_receiver(lv[2]), .tone_on_time_met(pl[4]),
    .tone_digit_detected(pl[5]), .tone_off_time_fail(pl[6]),
    .second_segment_detect(lv[3]), .noise_segment_detect(lv[4]),
    .training_start(pl[7]), .training_success(pl[8]),
    .handshake_start(pl[9]), .handshake_end(pl[10]), .auto_mode(lv[5]),
    .tx_char(tx_char), .tx_parity_bit(tx_parity_bit),
    .tx_parity_on(tx_parity_on), .irq(irq),
    .originate_active(originate_active),
    .answer_tone_send(answer_tone_send), .config_applied(),
    .async_active(async_active), .off_hook_relay_n(relay_a_n),
    .relay_n_a(relay_b_n));

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic pulse(input int i);
    @(posedge clk);
    pl[i] <= 1'b1;
    @(posedge clk);
    pl[i] <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
  endtask

  task automatic load(input logic [7:0] v, input logic n);
    @(posedge clk);
    rx_data     <= v;
    rx_ninth_in <= n;
    pulse(1);
  endtask

  // tone sampled mid-handshake
  task automatic shake(input logic exp);
    pulse(9);
    check({7'h0, answer_tone_send}, {7'h0, exp});
    pulse(10);
  endtask

  task automatic stop_test();
    $display("errors=%0d compares=%0d", error_cnt, compares);
    if (error_cnt == 0 && compares > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // runs take a few hundred cycles
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      error_cnt++;
      stop_test();
    end
  end

  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    foreach (addrs[i]) begin
      host.rd(addrs[i], d);
      check(d, 8'h00);
    end
    check({6'h0, relay_a_n, relay_b_n}, 8'h03);
    // all ones: controls keep their bits, status refuses
    foreach (addrs[i]) host.wr(addrs[i], 8'hFF);
    host.wr(8'h30, 8'hFF);
    host.rd(8'h04, d); check(d, 8'h80);
    host.rd(8'h06, d); check(d, 8'h08);
    host.rd(8'h07, d); check(d, 8'h02);
    host.rd(8'h09, d); check(d, 8'h90);
    host.rd(8'h0D, d); check(d, 8'h00);
    host.rd(8'h11, d); check(d, 8'h60);
    host.rd(8'h1B, d); check(d, 8'h00);
    host.rd(8'h30, d); check(d, 8'h00);
    check({6'h0, relay_a_n, relay_b_n}, 8'h00);
    host.wr(8'h04, 8'h00);
    host.wr(8'h07, 8'h00);
    host.wr(8'h06, 8'h00);
    host.wr(8'h1F, 8'h00);
    check({6'h0, relay_a_n, relay_b_n}, 8'h03);
    // new status, masked then enabled
    pulse(0);
    check({7'h0, irq}, 8'h00);
    host.rd(8'h1F, d); check(d & 8'hF8, 8'h08);
    host.wr(8'h1F, 8'h10);
    pulse(0);
    check({7'h0, irq}, 8'h01);
    host.rd(8'h1F, d); check(d & 8'hF8, 8'h98);
    host.wr(8'h1F, 8'h18);
    check({7'h0, irq}, 8'h01);
    host.wr(8'h1F, 8'h10);
    check({7'h0, irq}, 8'h00);
    host.rd(8'h1F, d); check(d, 8'h10);
    // call mode and answer tone
    host.apply_config(8'h10);
    repeat (3) @(posedge clk);
    check({7'h0, originate_active}, 8'h01);
    host.rd(8'h1F, d); check(d & 8'h01, 8'h00);
    shake(1'b0);
    host.apply_config(8'h80);
    repeat (3) @(posedge clk);
    check({7'h0, originate_active}, 8'h00);
    shake(1'b0);
    lv[5] <= 1'b1;
    shake(1'b1);
    lv[5] <= 1'b0;
    host.apply_config(8'h00);
    shake(1'b1);
    // async receive
    host.async_on(1'b1);
    host.wr(8'h11, 8'h40);
    load(8'h01, 1'b0);
    host.rd(8'h0A, d); check(d, 8'h20);
    load(8'h01, 1'b1);
    host.rd(8'h0A, d); check(d, 8'h08);
    host.rd(8'h00, d); check(d, 8'h01);
    host.rd(8'h0A, d); check(d, 8'h08);
    host.clear_overrun();
    host.rd(8'h0A, d); check(d, 8'h00);
    load(8'h01, 1'b1);
    host.rd(8'h00, d);
    load(8'h01, 1'b1);
    host.rd(8'h0A, d); check(d, 8'h00);
    host.rd(8'h21, d); check(d, 8'h00);
    // each parity method: three ones, ninth bit one
    host.wr(8'h20, 8'h05);
    for (int m = 0; m < 4; m++) begin
      host.wr(8'h11, {1'b0, m[1:0], 5'h00});
      repeat (3) @(posedge clk);
      #1 check({7'h0, tx_parity_bit}, {7'h0, m == 0 || m == 2});
      check({6'h0, async_active, tx_parity_on}, 8'h03);
    end
    // synchronous HDLC: bad CRC and overrun; then voice first low byte
    host.rd(8'h00, d);
    host.wr(8'h20, 8'h00);
    lv[0] <= 1'b1;
    pulse(2);
    host.rd(8'h0A, d); check(d & 8'h20, 8'h20);
    load(8'h55, 1'b0);
    load(8'hAA, 1'b0);
    host.rd(8'h0A, d); check(d & 8'h08, 8'h08);
    host.clear_overrun();
    host.rd(8'h0A, d); check(d & 8'h08, 8'h00);
    lv[0] <= 1'b0;
    lv[1] <= 1'b1;
    pulse(3);
    host.rd(8'h0A, d); check(d & 8'h20, 8'h20);
    host.rd(8'h21, d); check(d, 8'h01);
    lv[1] <= 1'b0;
    // on-time flag set and cleared
    lv[2] <= 1'b1;
    pulse(4);
    host.rd(8'h1B, d); check(d, 8'h20);
    pulse(5);
    host.rd(8'h1B, d); check(d, 8'h00);
    pulse(4);
    pulse(6);
    host.rd(8'h1B, d); check(d, 8'h00);
    lv[2] <= 1'b0;
    pulse(4);
    host.rd(8'h1B, d); check(d, 8'h00);
    // training segment flags and success
    lv[3] <= 1'b1;
    host.rd(8'h0D, d); check(d, 8'h80);
    lv[4] <= 1'b1;
    host.rd(8'h0D, d); check(d, 8'hC0);
    lv[3] <= 1'b0;
    lv[4] <= 1'b0;
    host.rd(8'h0D, d); check(d, 8'h00);
    pulse(8);
    host.rd(8'h0A, d); check(d & 8'h80, 8'h80);
    pulse(7);
    host.rd(8'h0A, d); check(d & 8'h80, 8'h00);
    stop_test();
  end
endmodule
`default_nettype wire
